/* File: src/angle_port_pkg.sv */
// constants for the sensor serial port slave: command word layout, lock keys,
// address windows, crc settings, transmit word reset value and port state encoding.
// assumes a single 100 MHz system clock; serial pins already synchronous to it.
package angle_port_pkg;

  // ----------------------------------------------------------------------------
  // word and command layout
  // ----------------------------------------------------------------------------
  localparam int unsigned WORD_BITS  = 16;
  localparam int unsigned CMD_RW_BIT = 15;
  localparam int unsigned CMD_KEY_HI = 14;
  localparam int unsigned CMD_KEY_LO = 11;
  localparam int unsigned CMD_UPD    = 10;
  localparam int unsigned CMD_ADR_HI = 9;
  localparam int unsigned CMD_ADR_LO = 4;
  localparam int unsigned CMD_CNT_HI = 3;
  localparam int unsigned CMD_CNT_LO = 0;

  // ----------------------------------------------------------------------------
  // lock keys and the address window each key opens
  // ----------------------------------------------------------------------------
  localparam logic [3:0] KEY_OPERATE = 4'h0;
  localparam logic [3:0] KEY_CONFIG  = 4'ha;
  localparam logic [5:0] OPER_LO     = 6'h00;
  localparam logic [5:0] OPER_HI     = 6'h04;
  localparam logic [5:0] CONF_LO     = 6'h05;
  localparam logic [5:0] CONF_HI     = 6'h11;

  // ----------------------------------------------------------------------------
  // crc and transmit word reset value
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  CRC_SEED = 8'hff;
  localparam logic [7:0]  CRC_POLY = 8'h1d;
  localparam logic [15:0] TX_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_STATUS,
    ST_DONE
  } port_state_t;

endpackage : angle_port_pkg

/* File: src/word_buffer.sv */
// two-entry buffer with valid/ready on both sides.
// assumes one clock; the drain side may hold out_ready low for any time.
`timescale 1ns/1ps
module word_buffer #(
  parameter int unsigned WIDTH = 23
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  initial begin
    if (WIDTH < 1) $error("word_buffer: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] slot_reg [2];
  logic             rd_ptr_reg;
  logic             wr_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = slot_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end else if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : word_buffer

/* File: src/angle_sensor_serial_port.sv */
// slave side of the sensor's three-wire serial port: command decode, lock check,
// register read/write requests, snapshot trigger, status word with crc.
// assumes sck, chip_select_n and data_in are synchronous to clk and slower than clk/4.
`timescale 1ns/1ps
module angle_sensor_serial_port #(
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned DATA_W = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              sck,
  input  wire logic              chip_select_n,
  input  wire logic              data_in,
  output logic                   data_out,
  output logic                   data_oe,
  input  wire logic              open_drain_select,
  input  wire logic [1:0]        sensor_number,
  input  wire logic              no_reset_flag,
  input  wire logic              system_ok,
  input  wire logic              angle_valid,
  output logic                   rd_req,
  output logic      [ADDR_W-1:0] rd_addr,
  output logic                   rd_upd,
  input  wire logic              rd_ack,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic                   wr_upd,
  output logic      [DATA_W-1:0] wr_data,
  output logic                   snapshot,
  output logic                   access_err
);

  initial begin
    if (ADDR_W != 6 || DATA_W != angle_port_pkg::WORD_BITS)
      $error("angle_sensor_serial_port: only 6-bit addresses and 16-bit words supported");
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] crc_bit(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[7] ^ b;
    crc_bit = {crc[6:0], 1'b0} ^ (fb ? angle_port_pkg::CRC_POLY : 8'h00);
  endfunction : crc_bit

  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] by);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = crc_bit(c, by[i]);
    end
    crc_byte = c;
  endfunction : crc_byte

  function automatic logic lock_ok(input logic [3:0] key, input logic [5:0] adr);
    lock_ok = ((key == angle_port_pkg::KEY_OPERATE) && (adr <= angle_port_pkg::OPER_HI)) ||
              ((key == angle_port_pkg::KEY_CONFIG) && (adr >= angle_port_pkg::CONF_LO) &&
               (adr <= angle_port_pkg::CONF_HI));
  endfunction : lock_ok

  // ----------------------------------------------------------------------------
  // pin edges
  // ----------------------------------------------------------------------------
  angle_port_pkg::port_state_t state_reg;
  logic        sck_prev_reg;
  logic        cs_n_prev_reg;
  logic        sck_seen_reg;
  logic [3:0]  bit_cnt_reg;
  logic [14:0] rx_shift_reg;
  logic [7:0]  crc_reg;
  logic [15:0] tx_word_reg;
  logic [15:0] tx_next_reg;
  logic        cur_ok_reg;
  logic        nxt_ok_reg;
  logic        out_bit_reg;
  logic        drive_reg;
  logic [3:0]  key_reg;
  logic        upd_reg;
  logic        with_status_reg;
  logic [4:0]  words_left_reg;
  logic [4:0]  fetch_left_reg;
  logic [5:0]  fetch_addr_reg;
  logic [5:0]  wr_addr_reg;
  logic        busy_reg;
  logic        err_reg;
  logic        snapshot_reg;

  logic        selected;
  logic        sck_rise;
  logic        sck_fall;
  logic        word_end;
  logic [15:0] rx_word;
  logic [7:0]  crc_next;
  logic        sending;
  logic        fetch_go;
  logic        fill;
  logic [15:0] fill_val;
  logic        lock_fail;
  logic        push_ok;
  logic        push_lost;
  logic        buf_ready;
  logic [15:0] status_word;
  logic [3:0]  resp_bits;
  logic [7:0]  status_crc;
  logic [4:0]  cmd_words;
  logic        fetch_ok;

  assign selected = ~chip_select_n;
  assign sck_rise = selected & sck & ~sck_prev_reg;
  assign sck_fall = selected & ~sck & sck_prev_reg;
  assign word_end = sck_fall && (bit_cnt_reg == 4'd15);
  assign rx_word  = {rx_shift_reg, data_in};
  assign sending  = (state_reg == angle_port_pkg::ST_RDATA) || (state_reg == angle_port_pkg::ST_STATUS);
  assign crc_next = crc_bit(crc_reg, sending ? out_bit_reg : data_in);
  assign cmd_words = (rx_word[3:0] == 4'd0) ? 5'd1 : {1'b0, rx_word[3:0]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_reg  <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg  <= sck;
      cs_n_prev_reg <= chip_select_n;
    end
  end

  // ----------------------------------------------------------------------------
  // snapshot: select pulse without any sck edge
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_seen_reg <= 1'b0;
      snapshot_reg <= 1'b0;
    end else begin
      snapshot_reg <= chip_select_n & ~cs_n_prev_reg & ~sck_seen_reg;
      if (chip_select_n) sck_seen_reg <= 1'b0;
      else if (sck_rise | sck_fall) sck_seen_reg <= 1'b1;
    end
  end

  assign snapshot = snapshot_reg;

  // ----------------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg       <= angle_port_pkg::ST_IDLE;
      bit_cnt_reg     <= 4'd0;
      rx_shift_reg    <= '0;
      key_reg         <= 4'd0;
      upd_reg         <= 1'b0;
      with_status_reg <= 1'b0;
      words_left_reg  <= 5'd0;
      wr_addr_reg     <= 6'd0;
    end else if (chip_select_n) begin
      state_reg   <= angle_port_pkg::ST_IDLE;
      bit_cnt_reg <= 4'd0;
    end else begin
      if (state_reg == angle_port_pkg::ST_IDLE) state_reg <= angle_port_pkg::ST_CMD;
      if (sck_fall) begin
        bit_cnt_reg  <= bit_cnt_reg + 4'd1;
        rx_shift_reg <= {rx_shift_reg[13:0], data_in};
      end
      if (word_end) begin
        unique case (state_reg)
          angle_port_pkg::ST_CMD: begin
            key_reg         <= rx_word[angle_port_pkg::CMD_KEY_HI:angle_port_pkg::CMD_KEY_LO];
            upd_reg         <= rx_word[angle_port_pkg::CMD_UPD];
            wr_addr_reg     <= rx_word[angle_port_pkg::CMD_ADR_HI:angle_port_pkg::CMD_ADR_LO];
            with_status_reg <= (rx_word[angle_port_pkg::CMD_CNT_HI:angle_port_pkg::CMD_CNT_LO] != 4'd0);
            words_left_reg  <= cmd_words;
            if (rx_word[angle_port_pkg::CMD_RW_BIT]) state_reg <= angle_port_pkg::ST_RDATA;
            else if (rx_word[3:0] == 4'd0) state_reg <= angle_port_pkg::ST_DONE;
            else state_reg <= angle_port_pkg::ST_WDATA;
          end
          angle_port_pkg::ST_WDATA, angle_port_pkg::ST_RDATA: begin
            words_left_reg <= words_left_reg - 5'd1;
            wr_addr_reg    <= wr_addr_reg + 6'd1;
            if (words_left_reg == 5'd1)
              state_reg <= with_status_reg ? angle_port_pkg::ST_STATUS : angle_port_pkg::ST_DONE;
          end
          angle_port_pkg::ST_STATUS: state_reg <= angle_port_pkg::ST_DONE;
          angle_port_pkg::ST_IDLE, angle_port_pkg::ST_DONE: state_reg <= angle_port_pkg::ST_DONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // crc over every bit on the wire until ST_DONE, seeded at each select
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) crc_reg <= angle_port_pkg::CRC_SEED;
    else if (chip_select_n) crc_reg <= angle_port_pkg::CRC_SEED;
    else if (sck_fall && state_reg != angle_port_pkg::ST_DONE) crc_reg <= crc_next;
  end

  assign resp_bits   = ~(4'b0001 << sensor_number);
  assign status_word = {no_reset_flag, system_ok, ~(err_reg | lock_fail | push_lost), angle_valid,
                        resp_bits, ~status_crc};
  assign status_crc  = crc_byte(crc_next, {no_reset_flag, system_ok, ~(err_reg | lock_fail | push_lost),
                                           angle_valid, resp_bits});

  // ----------------------------------------------------------------------------
  // read fetch: prefetch one word ahead so consecutive words need no gap
  // ----------------------------------------------------------------------------
  assign fetch_go = (state_reg == angle_port_pkg::ST_RDATA) && (fetch_left_reg != 5'd0) &&
                    ~busy_reg && ~(cur_ok_reg & nxt_ok_reg);
  assign fetch_ok = lock_ok(key_reg, fetch_addr_reg);
  assign lock_fail = (fetch_go & ~fetch_ok) |
                     (word_end && state_reg == angle_port_pkg::ST_WDATA && ~lock_ok(key_reg, wr_addr_reg));
  // locked addresses read back as zero rather than stalling the word
  assign fill     = (busy_reg & rd_ack) | (fetch_go & ~fetch_ok);
  assign fill_val = (busy_reg & rd_ack) ? rd_data : angle_port_pkg::TX_RESET;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_left_reg <= 5'd0;
      fetch_addr_reg <= 6'd0;
      busy_reg       <= 1'b0;
    end else if (chip_select_n) begin
      fetch_left_reg <= 5'd0;
      busy_reg       <= 1'b0;
    end else begin
      if (word_end && state_reg == angle_port_pkg::ST_CMD && rx_word[angle_port_pkg::CMD_RW_BIT]) begin
        fetch_left_reg <= cmd_words;
        fetch_addr_reg <= rx_word[angle_port_pkg::CMD_ADR_HI:angle_port_pkg::CMD_ADR_LO];
      end else if (fetch_go) begin
        fetch_left_reg <= fetch_left_reg - 5'd1;
        fetch_addr_reg <= fetch_addr_reg + 6'd1;
      end
      if (fetch_go & fetch_ok) busy_reg <= 1'b1;
      else if (rd_ack) busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_req  <= 1'b0;
      rd_addr <= '0;
      rd_upd  <= 1'b0;
    end else begin
      rd_req <= fetch_go & fetch_ok & selected;
      if (fetch_go) begin
        rd_addr <= fetch_addr_reg;
        rd_upd  <= upd_reg;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_word_reg <= angle_port_pkg::TX_RESET;
      tx_next_reg <= angle_port_pkg::TX_RESET;
      cur_ok_reg  <= 1'b0;
      nxt_ok_reg  <= 1'b0;
    end else if (chip_select_n) begin
      cur_ok_reg <= 1'b0;
      nxt_ok_reg <= 1'b0;
    end else if (word_end && (state_reg == angle_port_pkg::ST_RDATA || state_reg == angle_port_pkg::ST_WDATA) &&
                 words_left_reg == 5'd1) begin
      tx_word_reg <= status_word;
      cur_ok_reg  <= with_status_reg;
      nxt_ok_reg  <= 1'b0;
    end else if (word_end && state_reg == angle_port_pkg::ST_RDATA) begin
      tx_word_reg <= (fill & ~nxt_ok_reg) ? fill_val : tx_next_reg;
      cur_ok_reg  <= nxt_ok_reg | fill;
      if (fill & nxt_ok_reg) tx_next_reg <= fill_val;
      nxt_ok_reg  <= fill & nxt_ok_reg;
    end else if (fill) begin
      if (~cur_ok_reg) begin
        tx_word_reg <= fill_val;
        cur_ok_reg  <= 1'b1;
      end else begin
        tx_next_reg <= fill_val;
        nxt_ok_reg  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // data pin: bit changes on sck rise, released whenever not sending
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_bit_reg <= 1'b1;
      drive_reg   <= 1'b0;
    end else if (chip_select_n) begin
      drive_reg <= 1'b0;
    end else if (word_end && (state_reg == angle_port_pkg::ST_STATUS ||
                              (state_reg == angle_port_pkg::ST_RDATA && words_left_reg == 5'd1 &&
                               ~with_status_reg))) begin
      drive_reg <= 1'b0;
    end else if (sck_rise && sending) begin
      out_bit_reg <= tx_word_reg[4'd15 - bit_cnt_reg];
      drive_reg   <= 1'b1;
    end
  end

  assign data_out = open_drain_select ? 1'b0 : out_bit_reg;
  assign data_oe  = drive_reg & (open_drain_select ? ~out_bit_reg : 1'b1);

  // ----------------------------------------------------------------------------
  // write words into the buffer; an overflow is reported, not silently dropped
  // ----------------------------------------------------------------------------
  assign push_ok   = word_end && state_reg == angle_port_pkg::ST_WDATA && lock_ok(key_reg, wr_addr_reg);
  assign push_lost = push_ok & ~buf_ready;

  word_buffer #(
    .WIDTH (DATA_W + ADDR_W + 1)
  ) u_write_buffer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_ok),
    .in_ready  (buf_ready),
    .in_data   ({wr_addr_reg, upd_reg, rx_word}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_upd, wr_data})
  );

  // ----------------------------------------------------------------------------
  // interface error: sticky until reported in a status word, set wins
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) err_reg <= 1'b0;
    else if (lock_fail | push_lost) err_reg <= 1'b1;
    else if (word_end && state_reg == angle_port_pkg::ST_STATUS) err_reg <= 1'b0;
  end

  assign access_err = err_reg;

endmodule : angle_sensor_serial_port

/* File: test/angle_port_asserts.sv */
// port-level checker for the sensor serial port slave.
// assumes it is bound onto angle_sensor_serial_port; one clock domain.
`timescale 1ns/1ps
module angle_port_asserts #(
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned DATA_W = 16
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              chip_select_n,
  input wire logic              open_drain_select,
  input wire logic              data_out,
  input wire logic              data_oe,
  input wire logic              rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic              rd_upd,
  input wire logic              wr_valid,
  input wire logic              wr_ready,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic              wr_upd,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              snapshot,
  input wire logic              access_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_OE_DESEL: assert property (chip_select_n && $past(chip_select_n) |-> !data_oe)
    else $error("data pin driven while deselected");
  AST_OD_LOW: assert property (data_oe && open_drain_select |-> !data_out)
    else $error("open-drain pin driven high");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !data_oe && !rd_req && !wr_valid && !snapshot && !access_err)
    else $error("outputs active after reset");
  AST_SNAP_SEL: assert property (snapshot |-> chip_select_n && $past(chip_select_n))
    else $error("snapshot while selected");
  AST_SNAP_PULSE: assert property (snapshot |=> !snapshot)
    else $error("snapshot longer than one cycle");
  AST_RD_PULSE: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  AST_RD_STAND: assert property (rd_req |=> $stable(rd_addr) && $stable(rd_upd))
    else $error("read address moved after request");
  AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_upd, wr_addr, wr_data}))
    else $error("write word changed while stalled");
  AST_RD_DESEL: assert property (chip_select_n && $past(chip_select_n, 3) |-> !rd_req)
    else $error("read request while deselected");
  COV_READ: cover property (rd_req);
  COV_WRITE: cover property (wr_valid && wr_ready);
  COV_SNAP: cover property (snapshot);
  COV_OD: cover property (data_oe && open_drain_select);
endmodule : angle_port_asserts

bind angle_sensor_serial_port angle_port_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .open_drain_select(open_drain_select),
  .data_out(data_out), .data_oe(data_oe), .rd_req(rd_req), .rd_addr(rd_addr), .rd_upd(rd_upd),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_upd(wr_upd), .wr_data(wr_data),
  .snapshot(snapshot), .access_err(access_err));

/* File: test/serial_master_model.sv */
// bus master model: drives clock and select, shifts words, resolves data pin.
// assumes a pull-up on the data pin; the bench calls its tasks.
`timescale 1ns/1ps
module serial_master_model (
  input  wire logic clk,
  output logic      sck,
  output logic      chip_select_n,
  output logic      data_in,
  input  wire logic data_out,
  input  wire logic data_oe
);
  logic m_oe;
  logic m_bit;
  // pull-up wins wherever nobody pulls low
  assign data_in = (data_oe ? data_out : 1'b1) & (m_oe ? m_bit : 1'b1);
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    m_oe = 1'b0;
    m_bit = 1'b1;
  end
  task automatic set_select(input logic on);
    repeat (11) @(posedge clk);
    chip_select_n <= !on;
    if (!on) repeat (61) @(posedge clk);
  endtask : set_select
  // change on rise, sample on fall, msb first; nbits < 16 only to abort
  task automatic shift_word(input logic [15:0] tx, input logic drive, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - nbits; i--) begin
      @(posedge clk);
      sck   <= 1'b1;
      m_oe  <= drive;
      m_bit <= tx[i];
      repeat (10) @(posedge clk);
      sck   <= 1'b0;
      rx[i] = data_in;
      repeat (9) @(posedge clk);
    end
    m_oe <= 1'b0;
  endtask : shift_word
endmodule : serial_master_model

/* File: test/angle_sensor_serial_port_test.sv */
// self-checking bench for the sensor serial port slave.
// assumes the master model and a register responder; pull-up on the pin.
`timescale 1ns/1ps
module angle_sensor_serial_port_test;
  logic        clk, sys_rst, sck, chip_select_n, data_in, data_out, data_oe;
  logic        open_drain_select, no_reset_flag, system_ok, angle_valid;
  logic [1:0]  sensor_number;
  logic        rd_req, rd_upd, rd_ack, wr_valid, wr_ready, wr_upd, snapshot, access_err;
  logic [5:0]  rd_addr, wr_addr;
  logic [15:0] rd_data, wr_data;
  logic        wr_stall, p1;
  logic [6:0]  a1;
  logic [31:0] wq[$];
  logic [15:0] rx;
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_snap = 0;
  int          seed = 32'h5207_4b16;

  angle_sensor_serial_port i_dut (.clk(clk), .sys_rst(sys_rst), .sck(sck), .chip_select_n(chip_select_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .open_drain_select(open_drain_select),
    .sensor_number(sensor_number), .no_reset_flag(no_reset_flag), .system_ok(system_ok),
    .angle_valid(angle_valid), .rd_req(rd_req), .rd_addr(rd_addr), .rd_upd(rd_upd), .rd_ack(rd_ack),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_upd(wr_upd),
    .wr_data(wr_data), .snapshot(snapshot), .access_err(access_err));
  serial_master_model i_master (.clk(clk), .sck(sck), .chip_select_n(chip_select_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // model helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] rdv(input logic [6:0] ua);
    return {ua[6] ? 8'hc3 : 8'h5a, 2'b00, ua[5:0]};
  endfunction : rdv
  // lock window per word: a multi-word access may cross out of the window
  function automatic logic lk(input logic [3:0] key, input logic [5:0] a);
    return (key == 4'h0 && a <= 6'h04) || (key == 4'ha && a >= 6'h05 && a <= 6'h11);
  endfunction : lk
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [15:0] w, input int nb);
    for (int i = 15; i > 15 - nb; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h1d : 8'h00);
    return c;
  endfunction : crc_step
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------------------
  // register side: answers reads two cycles late, stalls writes at random
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    p1       <= rd_req;
    a1       <= {rd_upd, rd_addr};
    rd_ack   <= p1;
    rd_data  <= rdv(a1);
    wr_ready <= !wr_stall && ($random(seed) % 3 != 0);
    if (snapshot) n_snap <= n_snap + 1;
    if (wr_valid && wr_ready) chk("write word", 32'({wr_upd, wr_addr, wr_data}), wq.pop_front());
  end
  // one whole transfer with its expected words; ok = every word passed the lock
  task automatic xfer(input logic rw, input logic [3:0] key, input logic upd, input logic [5:0] adr,
                      input logic [3:0] cnt);
    logic [15:0] cmd, w, st;
    logic [7:0]  crc;
    logic [5:0]  a;
    logic        ok;
    int          n;
    cmd = {rw, key, upd, adr, cnt};
    n = (cnt == 4'h0 && rw) ? 1 : int'(cnt);
    ok = 1'b1;
    crc = crc_step(8'hff, cmd, 16);
    {no_reset_flag, system_ok, angle_valid, sensor_number} <= 5'($random(seed));
    i_master.set_select(1'b1);
    i_master.shift_word(cmd, 1'b1, 16, rx);
    for (int i = 0; i < n; i++) begin
      a = 6'(adr + i);
      ok = ok & lk(key, a);
      w = rw ? (lk(key, a) ? rdv({upd, a}) : 16'h0000) : 16'($random(seed));
      if (!rw && lk(key, a)) wq.push_back(32'({upd, a, w}));
      i_master.shift_word(w, !rw, 16, rx);
      if (rw) chk("read word", 32'(rx), 32'(w));
      crc = crc_step(crc, w, 16);
    end
    chk("access error flag", 32'(access_err), 32'(!ok));
    if (cnt == 4'h0) chk("pin after last word", 32'(data_oe), 32'h0);
    if (cnt != 4'h0) begin
      st = {no_reset_flag, system_ok, ok, angle_valid, ~(4'b0001 << sensor_number), 8'h00};
      st[7:0] = ~crc_step(crc, st, 8);
      i_master.shift_word(st, 1'b0, 16, rx);
      chk("status word", 32'(rx), 32'(st));
    end
    i_master.set_select(1'b0);
    chk("pin released", 32'(data_oe), 32'h0);
    $display("transfer %h done", cmd);
  endtask : xfer

  initial begin
    sys_rst = 1'b1;
    open_drain_select = 1'b0;
    {no_reset_flag, system_ok, angle_valid, sensor_number} = 5'($random(seed));
    wr_stall = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    xfer(1'b1, 4'h0, 1'b0, 6'h02, 4'h1);
    xfer(1'b1, 4'ha, 1'b1, 6'h05, 4'h3);
    xfer(1'b1, 4'h0, 1'b0, 6'h04, 4'h0);
    xfer(1'b0, 4'ha, 1'b0, 6'h07, 4'h1);
    xfer(1'b1, 4'h0, 1'b0, 6'h06, 4'h1);
    xfer(1'b1, 4'h5, 1'b0, 6'h01, 4'h1);
    xfer(1'b0, 4'h0, 1'b1, 6'h09, 4'h1);
    xfer(1'b1, 4'ha, 1'b0, 6'h04, 4'h1);
    xfer(1'b1, 4'ha, 1'b0, 6'h11, 4'h2);
    xfer(1'b1, 4'h0, 1'b0, 6'h3f, 4'h2);
    chk("snapshots during clocked transfers", 32'(n_snap), 32'h0);
    i_master.set_select(1'b1);
    i_master.set_select(1'b0);
    chk("snapshot count", 32'(n_snap), 32'h1);
    $display("snapshot test done");
    i_master.set_select(1'b1);
    i_master.shift_word(16'h8021, 1'b1, 16, rx);
    i_master.shift_word(16'h0000, 1'b0, 8, rx);
    chk("pin mid word", 32'(data_oe), 32'h1);
    chk("partial read word", 32'(rx), 32'(rdv(7'h02) & 16'hff00));
    i_master.set_select(1'b0);
    chk("pin after abort", 32'(data_oe), 32'h0);
    $display("abort test done");
    xfer(1'b1, 4'h0, 1'b1, 6'h03, 4'h1);
    open_drain_select <= 1'b1;
    xfer(1'b1, 4'h0, 1'b0, 6'h00, 4'h2);
    open_drain_select <= 1'b0;
    wr_stall <= 1'b1;
    xfer(1'b0, 4'ha, 1'b1, 6'h0c, 4'h2);
    chk("words held while stalled", 32'(wq.size()), 32'h2);
    wr_stall <= 1'b0;
    for (int i = 0; i < 100 && wq.size() != 0; i++) @(posedge clk);
    chk("words drained", 32'(wq.size()), 32'h0);
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : angle_sensor_serial_port_test
